// >>> src/uart9_pkg.sv
// Summary of operation
// - Both mode-select bits set selects variable-rate 9-bit full-duplex mode.
// - Frame: low start, eight data bits LSB first, ninth bit, high stop.
// - Transmitter sends the tx_ninth_bit control bit as each frame's ninth bit.
// - Accepted frame's ninth bit is stored in the rx_ninth_bit status bit.
// - Accept when done flag clear and filter off, or ninth bit one with an address match; set flag.
// - Rejected frames leave data buffer, ninth-bit status and done flag untouched.
// - Receiver always returns to watching for the next start edge.
// - Received stop bit value never affects buffer, ninth bit or done flag.
// - Address recognition works only in 9-bit modes with filter bit set.
// - With filtering on, frames with ninth bit zero are dropped silently.
// - With filtering on, address frames must match the slave address to flag.
// - Comparison only checks bit positions whose mask bit is one.
// - The broadcast address matches on every slave.
// - In idle low-power mode only a matching address causes a wake-up.
// - Writing the data buffer loads the shifter and starts a frame.
// - After the last bit, sending ends and the transmit-done flag sets.
// - Reception needs receive enable; falling edge starts it and resets timing.
// - Mode 11 bit rate comes from a timer overflow, mode 10 from a fixed clock divide; single-cycle mode is twelve times faster.
package uart9_pkg;

  localparam int unsigned APB_ADDR_W = 12;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [7:0] CTRL_INDEX  = 8'h98;
  localparam logic [7:0] DATA_INDEX  = 8'h99;
  localparam logic [7:0] BAUD_INDEX  = 8'h9a;
  localparam logic [7:0] POWER_INDEX = 8'h9c;
  localparam logic [7:0] ADDR_INDEX  = 8'ha9;
  localparam logic [7:0] MASK_INDEX  = 8'hb9;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int unsigned MODE_HIGH_BIT = 7;
  localparam int unsigned MODE_LOW_BIT  = 6;
  localparam int unsigned FILTER_BIT    = 5;
  localparam int unsigned RX_ENABLE_BIT = 4;
  localparam int unsigned TX_NINTH_BIT  = 3;
  localparam int unsigned RX_NINTH_BIT  = 2;
  localparam int unsigned TX_DONE_BIT   = 1;
  localparam int unsigned RX_DONE_BIT   = 0;
  localparam int unsigned BAUD_1T_BIT   = 16;

  // ****************************************************************
  // Reset values and counts
  // ****************************************************************
  localparam logic [7:0]  CTRL_RESET        = 8'h00;
  localparam logic [7:0]  ADDR_RESET        = 8'h00;
  localparam logic [7:0]  MASK_RESET        = 8'h00;
  localparam logic [15:0] RELOAD_RESET      = 16'hfff0;
  localparam logic [15:0] TIMER_TOP         = 16'hffff;
  localparam logic [3:0]  PRESCALE_LAST     = 4'hb;
  localparam logic [1:0]  FIXED_DIV_LAST    = 2'h3;
  localparam logic [3:0]  MID_TICK          = 4'h7;
  localparam logic [3:0]  LAST_TICK         = 4'hf;
  localparam logic [3:0]  RX_LAST_BIT       = 4'h8;
  localparam logic [3:0]  TX_LAST_BIT       = 4'ha;
  localparam logic [7:0]  BROADCAST_ADDRESS = 8'hff;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_SHIFT = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_type;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_type;

endpackage

// >>> src/uart_ninebit_address_filter.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module uart_ninebit_address_filter
(
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  input  wire logic                             clk_en,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [uart9_pkg::APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             rx_pin,
  output logic                                  tx_pin,
  output logic                                  rx_done,
  output logic                                  tx_done,
  output logic                                  wake
);
  import uart9_pkg::*;

  // ****************************************************************
  // Registers and internal state
  // ****************************************************************
  logic [7:0]   ctrl;
  logic [7:0]   slave_address;
  logic [7:0]   slave_address_mask;
  logic [7:0]   rx_buffer;
  logic [15:0]  baud_reload;
  logic         baud_single;
  logic         idle_mode;
  logic [3:0]   prescale;
  logic [15:0]  baud_timer;
  logic [1:0]   fixed_count;
  logic         baud_tick;
  logic         rx_meta;
  logic         rx_sync;
  logic         rx_prev;
  rx_state_type rx_state;
  logic [3:0]   rx_phase;
  logic [3:0]   rx_count;
  logic [8:0]   rx_shift;
  tx_state_type tx_state;
  logic [3:0]   tx_phase;
  logic [3:0]   tx_count;
  logic [10:0]  tx_shift;

  logic       nine_bit_mode;
  logic       filter_on;
  logic       apb_done;
  logic       wr_ctrl;
  logic       wr_data;
  logic [7:0] reg_index;
  logic       rx_fall;
  logic       rx_sample;
  logic       frame_end;
  logic       addr_match;
  logic       accept;
  logic       tx_start;
  logic       tx_bit_end;
  logic       tx_finish;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  assign nine_bit_mode = ctrl[MODE_HIGH_BIT];
  assign filter_on     = nine_bit_mode & ctrl[FILTER_BIT];
  assign apb_done      = clk_en & psel & penable & pready;
  assign reg_index     = paddr[9:2];
  assign wr_ctrl       = apb_done & pwrite & (paddr[11:10] == 2'b00) & (reg_index == CTRL_INDEX);
  assign wr_data       = apb_done & pwrite & (paddr[11:10] == 2'b00) & (reg_index == DATA_INDEX);

  // ****************************************************************
  // APB slave: one wait state, registered answer
  // ****************************************************************
  always_comb
  begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00)
      next_pslverr = 1'b1;
    else
    begin
      case (reg_index)
        CTRL_INDEX:  next_prdata = {24'h00_0000, ctrl};
        DATA_INDEX:  next_prdata = {24'h00_0000, rx_buffer};
        BAUD_INDEX:  next_prdata = {15'h0000, baud_single, baud_reload};
        POWER_INDEX: next_prdata = {31'h0000_0000, idle_mode};
        ADDR_INDEX:  next_prdata = {24'h00_0000, slave_address};
        MASK_INDEX:  next_prdata = {24'h00_0000, slave_address_mask};
        default:     next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= psel & penable & ~pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr & psel & penable & ~pready;
    end
  end

  // Plain configuration registers; an erroring write stores nothing
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      slave_address      <= ADDR_RESET;
      slave_address_mask <= MASK_RESET;
      baud_reload        <= RELOAD_RESET;
      baud_single        <= 1'b0;
    end
    else if (apb_done && pwrite && !pslverr)
    begin
      if (reg_index == ADDR_INDEX)
        slave_address <= pwdata[7:0];
      if (reg_index == MASK_INDEX)
        slave_address_mask <= pwdata[7:0];
      if (reg_index == BAUD_INDEX)
      begin
        baud_reload <= pwdata[15:0];
        baud_single <= pwdata[BAUD_1T_BIT];
      end
    end
  end

  // ****************************************************************
  // Control register: hardware events override a same-cycle write
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ctrl <= CTRL_RESET;
    else if (clk_en)
    begin
      if (wr_ctrl && !pslverr)
        ctrl <= pwdata[7:0];
      if (accept)
      begin
        ctrl[RX_NINTH_BIT] <= rx_shift[8];
        ctrl[RX_DONE_BIT]  <= 1'b1;
      end
      if (tx_finish)
        ctrl[TX_DONE_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_done <= 1'b0;
      tx_done <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_done <= ctrl[RX_DONE_BIT];
      tx_done <= ctrl[TX_DONE_BIT];
    end
  end

  // ****************************************************************
  // Bit-rate generator: 16 ticks per bit
  // ****************************************************************
  // Mode 11 uses the reloading timer; mode 10 a fixed clock divide
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prescale    <= 4'h0;
      // Start at the reset reload, not zero, or the first tick is 65536 counts away
      baud_timer  <= RELOAD_RESET;
      fixed_count <= 2'h0;
      baud_tick   <= 1'b0;
    end
    else if (clk_en)
    begin
      baud_tick <= 1'b0;
      if (ctrl[MODE_LOW_BIT])
      begin
        if (baud_single || prescale == PRESCALE_LAST)
        begin
          prescale <= 4'h0;
          if (baud_timer == TIMER_TOP)
          begin
            baud_timer <= baud_reload;
            baud_tick  <= 1'b1;
          end
          else
            baud_timer <= baud_timer + 16'h0001;
        end
        else
          prescale <= prescale + 4'h1;
      end
      else
      begin
        fixed_count <= fixed_count + 2'h1;
        if (fixed_count == FIXED_DIV_LAST)
          baud_tick <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end
    else if (clk_en)
    begin
      rx_meta <= rx_pin;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  assign rx_fall    = rx_prev & ~rx_sync;
  assign rx_sample  = clk_en & baud_tick & (rx_phase == MID_TICK);
  assign frame_end  = (rx_state == RX_STOP) & rx_sample;
  assign addr_match = (((rx_shift[7:0] ^ slave_address) & slave_address_mask) == 8'h00)
                    | (rx_shift[7:0] == BROADCAST_ADDRESS);
  // Stop bit level is never looked at
  assign accept = frame_end & ~ctrl[RX_DONE_BIT]
                & (~filter_on | (rx_shift[8] & addr_match));

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_state <= RX_IDLE;
      rx_phase <= 4'h0;
      rx_count <= 4'h0;
      rx_shift <= 9'h000;
    end
    else if (clk_en)
    begin
      if (baud_tick)
        rx_phase <= rx_phase + 4'h1;
      case (rx_state)
        RX_IDLE:
          if (ctrl[RX_ENABLE_BIT] && nine_bit_mode && rx_fall)
          begin
            rx_state <= RX_START;
            rx_phase <= 4'h0;
          end
        RX_START:
          if (rx_sample)
          begin
            rx_count <= 4'h0;
            rx_state <= rx_sync ? RX_IDLE : RX_SHIFT;
          end
        RX_SHIFT:
          if (rx_sample)
          begin
            rx_shift <= {rx_sync, rx_shift[8:1]};
            rx_count <= rx_count + 4'h1;
            if (rx_count == RX_LAST_BIT)
              rx_state <= RX_STOP;
          end
        RX_STOP:
          if (rx_sample)
            rx_state <= RX_IDLE;
        default:
          rx_state <= RX_IDLE;
      endcase
    end
  end

  // Rejected frames leave the read buffer alone
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rx_buffer <= 8'h00;
    else if (accept)
      rx_buffer <= rx_shift[7:0];
  end

  // ****************************************************************
  // Idle power mode and wake-up
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      idle_mode <= 1'b0;
      wake      <= 1'b0;
    end
    else if (clk_en)
    begin
      wake <= 1'b0;
      if (apb_done && pwrite && !pslverr && reg_index == POWER_INDEX)
        idle_mode <= pwdata[0];
      if (accept && filter_on && idle_mode)
      begin
        wake      <= 1'b1;
        idle_mode <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  // A write while a frame is in flight is dropped rather than corrupting it
  assign tx_start   = wr_data & ~pslverr & nine_bit_mode & (tx_state == TX_IDLE);
  assign tx_bit_end = clk_en & baud_tick & (tx_phase == LAST_TICK) & (tx_state == TX_SEND);
  assign tx_finish  = tx_bit_end & (tx_count == TX_LAST_BIT);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_state <= TX_IDLE;
      tx_phase <= 4'h0;
      tx_count <= 4'h0;
      tx_shift <= 11'h7ff;
      tx_pin   <= 1'b1;
    end
    else if (clk_en)
    begin
      case (tx_state)
        TX_IDLE:
          if (tx_start)
          begin
            tx_shift <= {1'b1, ctrl[TX_NINTH_BIT], pwdata[7:0], 1'b0};
            tx_pin   <= 1'b0;
            tx_phase <= 4'h0;
            tx_count <= 4'h0;
            tx_state <= TX_SEND;
          end
        TX_SEND:
        begin
          if (baud_tick)
            tx_phase <= tx_phase + 4'h1;
          if (tx_bit_end)
          begin
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_pin   <= tx_shift[1];
            tx_count <= tx_count + 4'h1;
            if (tx_finish)
            begin
              tx_state <= TX_IDLE;
              tx_pin   <= 1'b1;
            end
          end
        end
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence frame_done_s;
    frame_end && clk_en;
  endsequence

  sequence write_buffer_s;
    tx_start;
  endsequence

  done_set_a: assert property (accept |=> ctrl[RX_DONE_BIT] && rx_buffer == $past(rx_shift[7:0]))
    else $error("accepted frame did not set done flag and buffer");
  drop_keep_a: assert property (frame_done_s ##0 !accept |=> $stable(rx_buffer))
    else $error("rejected frame changed the read buffer");
  rx_return_a: assert property (frame_done_s |=> rx_state == RX_IDLE)
    else $error("receiver did not return to idle after the stop bit");
  data_drop_a: assert property (frame_done_s ##0 (filter_on && !rx_shift[8]) |-> !accept)
    else $error("filtered data frame was accepted");
  mask_match_a: assert property (frame_done_s ##0 (filter_on && rx_shift[8]
      && ((rx_shift[7:0] ^ slave_address) & slave_address_mask) != 8'h00
      && rx_shift[7:0] != BROADCAST_ADDRESS) |-> !accept)
    else $error("mismatching address frame was accepted");
  tx_load_a: assert property (write_buffer_s |=> tx_state == TX_SEND && !tx_pin
      && tx_shift[9] == $past(ctrl[TX_NINTH_BIT]))
    else $error("buffer write did not start a frame with the ninth bit");
  tx_end_a: assert property (tx_finish |=> tx_state == TX_IDLE && tx_pin && ctrl[TX_DONE_BIT])
    else $error("frame end did not set transmit-done");
  wake_cause_a: assert property ($rose(wake) |-> $past(accept && filter_on))
    else $error("wake without a matched address");
  rx_gate_a: assert property (rx_state == RX_IDLE && !ctrl[RX_ENABLE_BIT] |=> rx_state == RX_IDLE)
    else $error("receiver started while disabled");

endmodule

// >>> tb/serial_node.sv
`timescale 1ns/1ps
module serial_node
#(
  parameter int BIT_CLKS = 64
)
(
  input  wire logic ref_clk,
  input  wire logic line_in,
  output logic      line_out
);
  logic [9:0] sh;
  logic [7:0] got_data;
  logic       got_ninth;
  logic       got_stop;
  int         got_cnt = 0;

  initial
  begin
    line_out = 1'b1;
  end

  // ****************************************************************
  // Master side of the shared line
  // ****************************************************************
  task automatic send(input logic [7:0] d, input logic n, input logic s);
    logic [10:0] f;
    f = {s, n, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge ref_clk);
      line_out <= f[i];
      repeat (BIT_CLKS - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    line_out <= 1'b1;
  endtask

  // Low for a quarter bit only, so the centre sample sees the line high again
  task automatic glitch();
    @(posedge ref_clk);
    line_out <= 1'b0;
    repeat (BIT_CLKS / 4) @(posedge ref_clk);
    line_out <= 1'b1;
    repeat (BIT_CLKS * 12) @(posedge ref_clk);
  endtask

  // ****************************************************************
  // Listener on the transmit pin, sampling at bit centres
  // ****************************************************************
  always
  begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge ref_clk);
    for (int i = 0; i < 10; i++)
    begin
      repeat (BIT_CLKS) @(posedge ref_clk);
      sh[i] = line_in;
    end
    {got_stop, got_ninth, got_data} = sh;
    got_cnt++;
  end
endmodule

// >>> tb/tb_uart_ninebit_address_filter.sv
`timescale 1ns/1ps
module tb_uart_ninebit_address_filter;
  import uart9_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] addr;
    logic [7:0] mask;
    logic [7:0] data;
    logic       pwr;
    logic       nb;
    logic       stop;
    logic       acc;
  } rx_case_type;

  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        clk_en  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_pin;
  logic        tx_pin;
  logic        rx_done;
  logic        tx_done;
  logic        wake;
  int          error_cnt   = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          wake_cnt    = 0;
  int          base;
  logic [31:0] q;
  logic        err;
  logic [7:0]  last_d = 8'h00;
  logic        rb8;
  rx_case_type cs;

  // Fields: control, address, mask, frame byte, then idle/ninth/stop/accept
  rx_case_type rx_cases [14] = '{
    36'hd000005a3, 36'hd10000116, 36'hd000003c5, 36'hc00000776, 36'h500000666,
    36'hf0ca81802, 36'hf0ca81836, 36'hf0ca81807, 36'hf0ca0f5a7, 36'hf0ca0f5b6,
    36'hf0ca0fff7, 36'hb0ca81807, 36'hf0ca8181e, 36'hf0ca81caf};

  uart_ninebit_address_filter u_dut
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rx_pin  (rx_pin),
    .tx_pin  (tx_pin),
    .rx_done (rx_done),
    .tx_done (tx_done),
    .wake    (wake)
  );

  serial_node u_node
  (
    .ref_clk  (ref_clk),
    .line_in  (tx_pin),
    .line_out (rx_pin)
  );

  always #20 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cycles++;
    if (wake === 1'b1)
      wake_cnt++;
    if (cycles == 40000)
    begin
      error_cnt++;
      results();
    end
  end

  // ****************************************************************
  // Bus and check helpers
  // ****************************************************************
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, {2'h0, idx, 2'h0}, d);
    chk(err, 1'b0);
  endtask

  task automatic rd(input logic [7:0] idx);
    apb(1'b0, {2'h0, idx, 2'h0}, 32'h0);
    chk(err, 1'b0);
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(CTRL_INDEX);
    chk(q, {24'h0, CTRL_RESET});
    rd(ADDR_INDEX);
    chk(q, {24'h0, ADDR_RESET});
    rd(MASK_INDEX);
    chk(q, {24'h0, MASK_RESET});
    rd(BAUD_INDEX);
    chk(q, {16'h0, RELOAD_RESET});
    chk(tx_pin, 1'b1);
    apb(1'b1, 12'h100, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, 12'h261, 32'h0);
    chk(err, 1'b1);
    $display("test registers done");

    // Single-cycle timer, four clocks a tick: 64 clocks a bit
    wr(BAUD_INDEX, 32'h0001fffc);
    for (int k = 0; k < 2; k++)
    begin
      wr(CTRL_INDEX, (k == 0) ? 32'hd8 : 32'hd0);
      base = u_node.got_cnt;
      wr(DATA_INDEX, 32'h5a + k);
      while (tx_done !== 1'b1) @(posedge ref_clk);
      chk(u_node.got_cnt - base, 1);
      chk(u_node.got_data, 8'h5a + k);
      chk(u_node.got_ninth, k == 0);
      chk(u_node.got_stop, 1'b1);
      rd(CTRL_INDEX);
      chk(q[1], 1'b1);
    end
    // Twelve-cycle timer, reload ffff: 12 clocks a tick, 176 ticks a frame
    wr(CTRL_INDEX, 32'hd0);
    wr(BAUD_INDEX, 32'h0000ffff);
    base = cycles;
    wr(DATA_INDEX, 32'h3c);
    while (tx_done !== 1'b1) @(posedge ref_clk);
    chk(((cycles - base) >= 2090) && ((cycles - base) <= 2180), 1'b1);
    wr(BAUD_INDEX, 32'h0001fffc);
    $display("test transmit done");

    foreach (rx_cases[i])
    begin
      cs = rx_cases[i];
      wr(ADDR_INDEX, cs.addr);
      wr(MASK_INDEX, cs.mask);
      wr(POWER_INDEX, cs.pwr);
      wr(CTRL_INDEX, cs.ctrl);
      base = wake_cnt;
      u_node.send(cs.data, cs.nb, cs.stop);
      repeat (8) @(posedge ref_clk);
      chk(rx_done, cs.acc | cs.ctrl[0]);
      chk(wake_cnt - base, cs.pwr & cs.acc);
      if (cs.acc)
        last_d = cs.data;
      rb8 = cs.acc ? cs.nb : cs.ctrl[2];
      rd(DATA_INDEX);
      chk(q, last_d);
      rd(CTRL_INDEX);
      chk(q, {cs.ctrl[7:3], rb8, 1'b0, cs.acc | cs.ctrl[0]});
      rd(ADDR_INDEX);
      chk(q, cs.addr);
    end
    $display("test receive filter done");

    wr(CTRL_INDEX, 32'hd0);
    u_node.glitch();
    chk(rx_done, 1'b0);
    u_node.send(8'h96, 1'b0, 1'b1);
    repeat (8) @(posedge ref_clk);
    chk(rx_done, 1'b1);
    wr(DATA_INDEX, 32'h42);
    rd(DATA_INDEX);
    chk(q, 8'h96);
    // Clock enable low must hold the start bit that the last write launched
    clk_en <= 1'b0;
    repeat (160) @(posedge ref_clk);
    chk(tx_pin, 1'b0);
    clk_en <= 1'b1;
    $display("test noise and buffer done");
    results();
  end
endmodule
